/* include/wp_consts.vh */
/*
 holds: constants for the watchpoint and debug control block
 assumes: included by bare name from core files
*/
`ifndef WP_CONSTS_VH
`define WP_CONSTS_VH
`define SCAN_LEN 38
`define SCAN_DATA_W 32
`define SCAN_ADDR_W 5
`define BANK_LSB 3
`define SETTLE_LEN 3
`define CTL_W 6
`define CTL_RESET 6'h00
`define CTL_DISABLE_BIT 5
`define CTL_ABORT_MODE_BIT 4
`define CTL_ZERO_BIT 3
`define CTL_INTERRUPT_DISABLE_BIT_BIT 2
`define CTL_FORCE_RQ_BIT 1
`define CTL_FORCE_ACK_BIT 0
`define ADDR_DEBUG_CTRL 5'h00
`define ADDR_WP0_BASE 5'h08
`define ADDR_WP1_BASE 5'h10
`define WP_AV 3'h0
`define WP_AM 3'h1
`define WP_DV 3'h2
`define WP_DM 3'h3
`define WP_CV 3'h4
`define WP_CM 3'h5
`define CV_W 9
`define CM_W 8
`define CV_ENABLE_BIT 8
`define CV_FETCH_DATA_BIT 3
`define SIZE_HALF 2'h1
`define ABORT_STATUS_RESET 32'h00000000
`endif

/* core/wp_comparator.v */
/*
 holds: one watchpoint comparator with value and mask registers
 assumes: register writes come from the scan update logic on the same clock
*/
`timescale 1ns/100ps
`include "wp_consts.vh"
module wp_comparator #(
    parameter DW = 32
) (
    // clock and reset
    input wire mclk_i,
    input wire nrst_i,
    // register write
    input wire wr_i,
    input wire [2:0] sel_i,
    input wire [DW-1:0] wdata_i,
    output reg [DW-1:0] rdata_o,
    // bus to compare
    input wire [DW-1:0] addr_i,
    input wire [DW-1:0] data_i,
    input wire [7:0] ctl_i,
    input wire half_fetch_i,
    input wire half_upper_i,
    output wire hit_o
);
    reg [DW-1:0] av_reg;
    reg [DW-1:0] am_reg;
    reg [DW-1:0] dv_reg;
    reg [DW-1:0] dm_reg;
    reg [`CV_W-1:0] cv_reg;
    reg [`CM_W-1:0] cm_reg;
    reg [DW-1:0] dsel;
    wire addr_ok;
    wire data_ok;
    wire ctl_ok;

    function masked_eq;
        input [DW-1:0] val;
        input [DW-1:0] msk;
        input [DW-1:0] in;
        begin
            masked_eq = &((val ~^ in) | msk);
        end
    endfunction

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            av_reg <= {DW{1'b0}};
            am_reg <= {DW{1'b1}};
            dv_reg <= {DW{1'b0}};
            dm_reg <= {DW{1'b1}};
            cv_reg <= {`CV_W{1'b0}};
            cm_reg <= {`CM_W{1'b1}};
        end else if (wr_i) begin
            case (sel_i)
                `WP_AV: av_reg <= wdata_i;
                `WP_AM: am_reg <= wdata_i;
                `WP_DV: dv_reg <= wdata_i;
                `WP_DM: dm_reg <= wdata_i;
                `WP_CV: cv_reg <= wdata_i[`CV_W-1:0];
                `WP_CM: cm_reg <= wdata_i[`CM_W-1:0];
                default: av_reg <= av_reg;
            endcase
        end
    end

    always @* begin
        case (sel_i)
            `WP_AV: rdata_o = av_reg;
            `WP_AM: rdata_o = am_reg;
            `WP_DV: rdata_o = dv_reg;
            `WP_DM: rdata_o = dm_reg;
            `WP_CV: rdata_o = {{(DW-`CV_W){1'b0}}, cv_reg};
            `WP_CM: rdata_o = {{(DW-`CM_W){1'b0}}, cm_reg};
            default: rdata_o = {DW{1'b0}};
        endcase
    end

    // 16-bit fetch: mirror the valid half so only it is compared
    always @* begin
        if (half_fetch_i && half_upper_i)
            dsel = {data_i[DW-1:DW/2], data_i[DW-1:DW/2]};
        else if (half_fetch_i)
            dsel = {data_i[DW/2-1:0], data_i[DW/2-1:0]};
        else
            dsel = data_i;
    end

    assign addr_ok = masked_eq(av_reg, am_reg, addr_i);
    assign data_ok = masked_eq(dv_reg, dm_reg, dsel);
    assign ctl_ok = &((cv_reg[7:0] ~^ ctl_i) | cm_reg);
    assign hit_o = cv_reg[`CV_ENABLE_BIT] & addr_ok & data_ok & ctl_ok;
endmodule

/* core/sync2.v */
/*
 holds: two flip-flop level synchroniser, vector wide
 assumes: inputs from outside the mclk_i domain
*/
`timescale 1ns/100ps
module sync2 #(
    parameter W = 1
) (
    // clock and reset
    input wire mclk_i,
    input wire nrst_i,
    // level
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta_reg;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule

/* core/watchpoint_debug_control.v */
/*
 holds: scan-chain watchpoint unit, debug control register, abort status
 assumes: tck/tdi and tap state flags come from pins, sampled on mclk_i;
 core bus signals are on mclk_i
*/
`timescale 1ns/100ps
`include "wp_consts.vh"
module watchpoint_debug_control #(
    parameter DW = 32
) (
    // clock and reset
    input wire mclk_i,
    input wire nrst_i,
    // scan chain pins and tap state flags
    input wire tck_i,
    input wire tdi_i,
    input wire shift_dr_i,
    input wire capture_dr_i,
    input wire update_dr_i,
    input wire run_test_idle_i,
    output reg tdo_o,
    // core bus for comparison
    input wire [DW-1:0] addr_i,
    input wire [DW-1:0] data_i,
    input wire write_i,
    input wire [1:0] size_i,
    input wire fetch_or_data_flag_i,
    input wire privilege_flag_i,
    input wire [1:0] external_condition_input_i,
    input wire half_fetch_i,
    input wire access_valid_i,
    // aborts
    input wire external_abort_i,
    // coprocessor transfers
    input wire coprocessor_write_transfer_i,
    input wire coprocessor_read_transfer_i,
    input wire [DW-1:0] cp_wdata_i,
    output reg [DW-1:0] cp_rdata_o,
    // debug handshake
    input wire debug_request_i,
    input wire core_internal_acknowledge_i,
    output reg forced_request_output_o,
    output reg debug_acknowledge_o,
    output reg core_interrupt_enable_o,
    output reg debug_break_o,
    output reg debug_abort_o
);
    // pin synchronisers
    wire [5:0] pins_s;
    wire tck_s;
    wire tdi_s;
    wire shift_s;
    wire capture_s;
    wire update_s;
    wire rti_s;
    reg tck_d_reg;
    reg update_d_reg;
    reg [`SCAN_LEN-1:0] scan_reg;
    reg [`CTL_W-1:0] ctl_reg;
    reg rq_latch_reg;
    reg debug_abort_flag_reg;
    reg [DW-1:0] rd_mux;
    wire tck_rise;
    wire tck_fall;
    wire upd_pulse;
    wire scan_wr;
    wire [`SCAN_ADDR_W-1:0] scan_addr;
    wire [DW-1:0] scan_data;
    wire [1:0] wp_wr;
    wire [DW-1:0] rdata0;
    wire [DW-1:0] rdata1;
    wire [1:0] hit;
    wire hit_any;
    wire take_abort;
    wire [7:0] ctl_bus0;
    wire [7:0] ctl_bus1;

    // scan address decode
    wire ctl_sel;
    wire [1:0] bank_sel;
    // tck edges are ignored until the pin pipeline holds real pin levels
    reg [`SETTLE_LEN-1:0] settle_reg;
    wire settled;

    sync2 #(.W(6)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({tck_i, tdi_i, shift_dr_i, capture_dr_i, update_dr_i, run_test_idle_i}),
        .q_o(pins_s)
    );
    assign tck_s = pins_s[5];
    assign tdi_s = pins_s[4];
    assign shift_s = pins_s[3];
    assign capture_s = pins_s[2];
    assign update_s = pins_s[1];
    assign rti_s = pins_s[0];

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tck_d_reg <= 1'b0;
            update_d_reg <= 1'b0;
            settle_reg <= {`SETTLE_LEN{1'b0}};
        end else begin
            tck_d_reg <= tck_s;
            update_d_reg <= update_s;
            settle_reg <= {settle_reg[`SETTLE_LEN-2:0], 1'b1};
        end
    end

    // the idle-high clock pin would otherwise look like a rise after reset
    assign settled = settle_reg[`SETTLE_LEN-1];
    assign tck_rise = settled & tck_s & ~tck_d_reg;
    assign tck_fall = settled & ~tck_s & tck_d_reg;

    // one access per entry into update-dr
    assign upd_pulse = update_s & ~update_d_reg;

    // chain: data[31:0], address[36:32], read/write[37]; shifted lsb first
    assign scan_data = scan_reg[`SCAN_DATA_W-1:0];
    assign scan_addr = scan_reg[`SCAN_DATA_W+`SCAN_ADDR_W-1:`SCAN_DATA_W];
    assign scan_wr = scan_reg[`SCAN_LEN-1];
    // true when a scan address lies in the register bank that starts at base
    function in_bank;
        input [`SCAN_ADDR_W-1:0] addr;
        input [`SCAN_ADDR_W-1:0] base;
        begin
            in_bank = (addr[`SCAN_ADDR_W-1:`BANK_LSB] == base[`SCAN_ADDR_W-1:`BANK_LSB]);
        end
    endfunction

    // bank decode shared by writes and reads
    assign ctl_sel = (scan_addr == `ADDR_DEBUG_CTRL);
    assign bank_sel[0] = in_bank(scan_addr, `ADDR_WP0_BASE);
    assign bank_sel[1] = in_bank(scan_addr, `ADDR_WP1_BASE);
    assign wp_wr[0] = upd_pulse & scan_wr & bank_sel[0];
    assign wp_wr[1] = upd_pulse & scan_wr & bank_sel[1];

    always @* begin
        if (ctl_sel)
            rd_mux = {{(DW-`CTL_W){1'b0}}, ctl_reg};
        else if (bank_sel[0])
            rd_mux = rdata0;
        else if (bank_sel[1])
            rd_mux = rdata1;
        else
            rd_mux = {DW{1'b0}};
    end

    // a read loads the data field at update, then it shifts out on the next scan
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scan_reg <= {`SCAN_LEN{1'b0}};
            tdo_o <= 1'b0;
        end else begin
            if (upd_pulse && !scan_wr)
                scan_reg[`SCAN_DATA_W-1:0] <= rd_mux;
            else if (shift_s && tck_rise)
                scan_reg <= {tdi_s, scan_reg[`SCAN_LEN-1:1]};
            if (tck_fall)
                tdo_o <= scan_reg[0];
        end
    end

    // control register written on scan write to its address
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            ctl_reg <= `CTL_RESET;
        else if (upd_pulse && scan_wr && ctl_sel) begin
            ctl_reg <= scan_data[`CTL_W-1:0];
            ctl_reg[`CTL_ZERO_BIT] <= 1'b0;
        end
    end

    // request latch transparent only in run-test-idle
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            rq_latch_reg <= 1'b0;
        else if (rti_s)
            rq_latch_reg <= ctl_reg[`CTL_FORCE_RQ_BIT];
    end

    // control bus in the bit order of the control value register
    function [7:0] pack_ctl;
        input ext;
        input prot1;
        input prot0;
        input [1:0] sz;
        input wr;
        begin
            // chain and range inputs are not wired and always read as zero
            pack_ctl = {1'b0, 1'b0, ext, prot1, prot0, sz, wr};
        end
    endfunction

    assign ctl_bus0 = pack_ctl(external_condition_input_i[0], privilege_flag_i,
                               fetch_or_data_flag_i, size_i, write_i);
    assign ctl_bus1 = pack_ctl(external_condition_input_i[1], privilege_flag_i,
                               fetch_or_data_flag_i, size_i, write_i);

    wp_comparator #(.DW(DW)) u_wp0 (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .wr_i(wp_wr[0]),
        .sel_i(scan_addr[2:0]),
        .wdata_i(scan_data),
        .rdata_o(rdata0),
        .addr_i(addr_i),
        .data_i(data_i),
        .ctl_i(ctl_bus0),
        .half_fetch_i(half_fetch_i),
        .half_upper_i(addr_i[1]),
        .hit_o(hit[0])
    );

    wp_comparator #(.DW(DW)) u_wp1 (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .wr_i(wp_wr[1]),
        .sel_i(scan_addr[2:0]),
        .wdata_i(scan_data),
        .rdata_o(rdata1),
        .addr_i(addr_i),
        .data_i(data_i),
        .ctl_i(ctl_bus1),
        .half_fetch_i(half_fetch_i),
        .half_upper_i(addr_i[1]),
        .hit_o(hit[1])
    );

    assign hit_any = access_valid_i & (|hit) & ~ctl_reg[`CTL_DISABLE_BIT];
    // an external abort on the same access takes priority over the debug abort
    assign take_abort = hit_any & ctl_reg[`CTL_ABORT_MODE_BIT] & ~external_abort_i;

    // sticky abort flag; a new debug abort wins over a software clear
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            debug_abort_flag_reg <= 1'b0;
        else if (take_abort)
            debug_abort_flag_reg <= 1'b1;
        else if (coprocessor_write_transfer_i && !cp_wdata_i[0])
            debug_abort_flag_reg <= 1'b0;
    end

    // status read data holds between coprocessor reads
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i)
            cp_rdata_o <= `ABORT_STATUS_RESET;
        else if (coprocessor_read_transfer_i)
            cp_rdata_o <= {{(DW-1){1'b0}}, debug_abort_flag_reg};
    end

    // debug handshake outputs
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            forced_request_output_o <= 1'b0;
            debug_acknowledge_o <= 1'b0;
            core_interrupt_enable_o <= 1'b0;
        end else begin
            forced_request_output_o <= rq_latch_reg | debug_request_i;
            debug_acknowledge_o <= core_internal_acknowledge_i
                | ctl_reg[`CTL_FORCE_ACK_BIT];
            core_interrupt_enable_o <= ~(ctl_reg[`CTL_INTERRUPT_DISABLE_BIT_BIT]
                | core_internal_acknowledge_i | ctl_reg[`CTL_FORCE_ACK_BIT]);
        end
    end

    // hit outputs, one cycle after the bus cycle that matched
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            debug_break_o <= 1'b0;
            debug_abort_o <= 1'b0;
        end else begin
            debug_break_o <= hit_any & ~ctl_reg[`CTL_ABORT_MODE_BIT];
            debug_abort_o <= take_abort;
        end
    end
endmodule

/* verif/watchpoint_debug_control_monitor.sv */
/*
 holds: port checker for the watchpoint and debug control block
 assumes: bound to every instance of the block
*/
`timescale 1ns/100ps
module watchpoint_debug_control_monitor #(
    parameter DW = 32
) (
    // clock and reset
    input wire mclk_i,
    input wire nrst_i,
    // watched ports
    input wire tck_i,
    input wire tdo_o,
    input wire external_abort_i,
    input wire coprocessor_write_transfer_i,
    input wire coprocessor_read_transfer_i,
    input wire [DW-1:0] cp_rdata_o,
    input wire debug_request_i,
    input wire core_internal_acknowledge_i,
    input wire forced_request_output_o,
    input wire debug_acknowledge_o,
    input wire core_interrupt_enable_o,
    input wire debug_break_o,
    input wire debug_abort_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    chk_ack_forward:
        assert property (core_internal_acknowledge_i |=> debug_acknowledge_o)
        else $error("acknowledge not forwarded");
    chk_irq_blocked:
        assert property (core_internal_acknowledge_i [*2] |=> !core_interrupt_enable_o)
        else $error("interrupts enabled while acknowledged");
    chk_request_forward:
        assert property (debug_request_i [*2] |=> forced_request_output_o)
        else $error("request not forwarded");
    chk_status_upper_zero:
        assert property (coprocessor_read_transfer_i |=> cp_rdata_o[DW-1:1] == 0)
        else $error("status upper bits not zero");
    chk_status_held:
        assert property (!coprocessor_read_transfer_i |=> $stable(cp_rdata_o))
        else $error("status read data moved");
    chk_mode_exclusive:
        assert property (!(debug_break_o && debug_abort_o))
        else $error("break and abort together");
    chk_ext_abort_wins:
        assert property (external_abort_i |=> !debug_abort_o)
        else $error("debug abort beside external abort");
    chk_flag_sticky:
        assert property ((debug_abort_o && !coprocessor_write_transfer_i) ##1
            (coprocessor_read_transfer_i && !coprocessor_write_transfer_i) |=> cp_rdata_o[0])
        else $error("abort flag not set");
    chk_tdo_quiet:
        assert property (tck_i [*6] |-> $stable(tdo_o))
        else $error("scan out moved without clock fall");
endmodule
bind watchpoint_debug_control watchpoint_debug_control_monitor #(.DW(DW)) u_mon (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tdo_o(tdo_o),
    .external_abort_i(external_abort_i),
    .coprocessor_write_transfer_i(coprocessor_write_transfer_i),
    .coprocessor_read_transfer_i(coprocessor_read_transfer_i), .cp_rdata_o(cp_rdata_o),
    .debug_request_i(debug_request_i),
    .core_internal_acknowledge_i(core_internal_acknowledge_i),
    .forced_request_output_o(forced_request_output_o),
    .debug_acknowledge_o(debug_acknowledge_o),
    .core_interrupt_enable_o(core_interrupt_enable_o),
    .debug_break_o(debug_break_o), .debug_abort_o(debug_abort_o));

/* verif/scan_host.sv */
/*
 holds: debug host that drives the scan chain pins
 assumes: the block samples these pins on its own clock
*/
`timescale 1ns/100ps
module scan_host (
    // scan pins towards the block
    output reg tck_o,
    output reg tdi_o,
    output reg shift_o,
    output reg update_o,
    output reg rti_o,
    // scan data from the block
    input wire tdo_i
);
    initial begin
        tck_o = 1'b1;
        tdi_o = 1'b0;
        shift_o = 1'b0;
        update_o = 1'b0;
        rti_o = 1'b0;
    end
    // tck idles high so the first fall presents bit 0 of the loaded field
    task access(input wr, input [4:0] a, input [31:0] d, output [31:0] q);
        reg [37:0] f;
        integer i;
        begin
            f = {wr, a, d};
            shift_o = 1'b1;
            #20;
            for (i = 0; i < 38; i = i + 1) begin
                tck_o = 1'b0;
                tdi_o = f[i];
                #40;
                if (i < 32) q[i] = tdo_i;
                tck_o = 1'b1;
                #40;
            end
            shift_o = 1'b0;
            tdi_o = ~tdi_o;
            #20;
            update_o = 1'b1;
            #50;
            update_o = 1'b0;
            #30;
        end
    endtask
    task idle;
        begin
            rti_o = 1'b1;
            #50;
            rti_o = 1'b0;
            #20;
        end
    endtask
endmodule

/* verif/tb_watchpoint_debug_control.sv */
/*
 holds: self-checking bench for the watchpoint and debug control block
 assumes: scan_host drives the scan pins, the bench drives core side
*/
`timescale 1ns/100ps
`include "wp_consts.vh"
module tb_watchpoint_debug_control;
    reg mclk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [31:0] a = 32'h0, d = 32'h0, cwd = 32'h0, r, keep;
    reg [1:0] sz = 2'h2;
    reg wr = 1'b0, fd = 1'b0, hf = 1'b0, vld = 1'b0, ext = 1'b0, cpw = 1'b0, cpr = 1'b0;
    reg rq = 1'b0, ack = 1'b0;
    wire tck, tdi, sh, upd, rti, tdo, frq, dack, core_interrupt_enable, brk, abt;
    wire [31:0] crd;
    integer n_mismatch = 0, comparisons = 0;
    always #2.5 mclk_i = ~mclk_i;
    scan_host u_scan_host (.tck_o(tck), .tdi_o(tdi), .shift_o(sh), .update_o(upd),
        .rti_o(rti), .tdo_i(tdo));
    watchpoint_debug_control u_watchpoint_debug_control (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .tck_i(tck), .tdi_i(tdi), .shift_dr_i(sh), .capture_dr_i(1'b0), .update_dr_i(upd),
        .run_test_idle_i(rti), .tdo_o(tdo), .addr_i(a), .data_i(d), .write_i(wr),
        .size_i(sz), .fetch_or_data_flag_i(fd), .privilege_flag_i(1'b0),
        .external_condition_input_i(2'h0), .half_fetch_i(hf), .access_valid_i(vld),
        .external_abort_i(ext), .coprocessor_write_transfer_i(cpw),
        .coprocessor_read_transfer_i(cpr), .cp_wdata_i(cwd), .cp_rdata_o(crd),
        .debug_request_i(rq), .core_internal_acknowledge_i(ack),
        .forced_request_output_o(frq), .debug_acknowledge_o(dack),
        .core_interrupt_enable_o(core_interrupt_enable), .debug_break_o(brk), .debug_abort_o(abt));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", comparisons, n_mismatch);
            if (n_mismatch == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task wreg(input [4:0] ad, input [31:0] v);
        u_scan_host.access(1'b1, ad, v, r);
    endtask
    // read data leaves on the scan after the access
    task rreg(input [4:0] ad, input [31:0] exp);
        begin
            u_scan_host.access(1'b0, ad, 32'h0, r);
            u_scan_host.access(1'b0, ad, 32'h0, r);
            chk(r, exp);
        end
    endtask
    task prog(input [4:0] b, input [31:0] av, am, dv, dm, input [8:0] cv, input [7:0] cm);
        begin
            wreg(b, av);
            wreg(b + 5'h1, am);
            wreg(b + 5'h2, dv);
            wreg(b + 5'h3, dm);
            wreg(b + 5'h4, {23'h0, cv});
            wreg(b + 5'h5, {24'h0, cm});
        end
    endtask
    task bus(input [31:0] ba, bd, input h, f, w, x, eb, ea);
        begin
            @(posedge mclk_i);
            a <= ba;
            d <= bd;
            hf <= h;
            fd <= f;
            wr <= w;
            ext <= x;
            vld <= 1'b1;
            @(posedge mclk_i);
            vld <= 1'b0;
            ext <= 1'b0;
            #1;
            chk({brk, abt}, {eb, ea});
        end
    endtask
    task cp(input w, input [31:0] v, input [31:0] exp);
        begin
            @(posedge mclk_i);
            cpw <= w;
            cpr <= ~w;
            cwd <= v;
            @(posedge mclk_i);
            cpw <= 1'b0;
            cpr <= 1'b0;
            #1;
            if (!w) chk(crd, exp);
        end
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        chk({core_interrupt_enable, frq, dack, brk, abt}, 5'h10);
        wreg(`ADDR_DEBUG_CTRL, 32'h3f);
        chk({frq, dack, core_interrupt_enable}, 3'b010);
        u_scan_host.idle;
        chk(frq, 1'b1);
        rreg(`ADDR_DEBUG_CTRL, 32'h37);
        rreg(5'h1f, 32'h0);
        wreg(`ADDR_DEBUG_CTRL, 32'h20);
        u_scan_host.idle;
        chk({frq, dack, core_interrupt_enable}, 3'b001);
        @(posedge mclk_i);
        rq <= 1'b1;
        ack <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rq <= 1'b0;
        ack <= 1'b0;
        #1;
        chk({frq, dack, core_interrupt_enable}, 3'b110);
        prog(`ADDR_WP0_BASE, 32'h1000, 32'h3, 0, 32'hffffffff, 9'h100, 8'hf7);
        bus(32'h1002, 0, 0, 0, 0, 0, 0, 0);
        wreg(`ADDR_DEBUG_CTRL, 32'h0);
        bus(32'h1002, 0, 0, 0, 0, 0, 1, 0);
        bus(32'h1004, 0, 0, 0, 0, 0, 0, 0);
        wreg(`ADDR_DEBUG_CTRL, 32'h30);
        wreg(`ADDR_DEBUG_CTRL, 32'h10);
        bus(32'h1000, 0, 0, 0, 0, 1, 0, 0);
        cp(0, 0, 32'h0);
        bus(32'h1000, 0, 0, 0, 0, 0, 0, 1);
        cp(0, 0, 32'h1);
        cp(1, 32'h1, 0);
        cp(0, 0, 32'h1);
        cp(1, 32'h0, 0);
        cp(0, 0, 32'h0);
        wreg(`ADDR_DEBUG_CTRL, 32'h20);
        prog(`ADDR_WP1_BASE, 0, 32'hffffffff, 32'hdfffdfff, 0, 9'h100, 8'hf7);
        wreg(`ADDR_DEBUG_CTRL, 32'h0);
        bus(32'h2000, 32'h1234dfff, 1, 0, 0, 0, 1, 0);
        bus(32'h2002, 32'hdfff1234, 1, 0, 0, 0, 1, 0);
        bus(32'h2002, 32'h1234dfff, 1, 0, 0, 0, 0, 0);
        bus(32'h2000, 32'h1234dfff, 0, 0, 0, 0, 0, 0);
        keep = 32'h1234dfff;
        bus(32'h2000, 32'hdfffdfff, 0, 0, 0, 0, 1, 0);
        bus(32'h2000, keep, 0, 0, 0, 0, 0, 0);
        wreg(`ADDR_DEBUG_CTRL, 32'h20);
        prog(`ADDR_WP0_BASE, 32'h3000, 0, 0, 32'hffffffff, 9'h10d, 8'hf0);
        wreg(`ADDR_DEBUG_CTRL, 32'h0);
        bus(32'h3000, 32'h5, 0, 1, 1, 0, 1, 0);
        bus(32'h3000, 32'h5, 0, 1, 0, 0, 0, 0);
        @(posedge mclk_i);
        sz <= `SIZE_HALF;
        bus(32'h3000, 32'h5, 0, 1, 1, 0, 0, 0);
        report_and_stop;
    end
endmodule
